// file: twet_ctl_model.sv
// Behavioural two-wire bus controller that drives the target's bus clock and data.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/10ps
module twet_ctl_model (
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    // ==========================================================
    // Bus primitives
    // ==========================================================
    // Clock idles high and stands still between frames.
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // One bit: data moves while clock is low, the line is read at mid high.
    task automatic bit_xfer(input logic b, output logic r);
        sda_rel = b;
        #16 scl = 1'b1;
        #16 r = sda;
        #16 scl = 1'b0;
        #16;
    endtask : bit_xfer

    // Start, also usable as a repeated start; the small offset keeps edges off clk.
    task automatic start;
        #1.3 sda_rel = 1'b1;
        #16 scl = 1'b1;
        #16 sda_rel = 1'b0;
        #16 scl = 1'b0;
        #16;
    endtask : start

    // Stop leaves both lines released.
    task automatic stop;
        #1.3 sda_rel = 1'b0;
        #16 scl = 1'b1;
        #16 sda_rel = 1'b1;
        #32;
    endtask : stop

    // Sends a byte high bit first and returns the acknowledge level.
    task automatic wbyte(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], r);
        bit_xfer(1'b1, ack_n);
    endtask : wbyte

    // Reads a byte with the line released, then answers with ack_n.
    task automatic rbyte(input logic ack_n, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, d[i]);
        bit_xfer(ack_n, r);
    endtask : rbyte
endmodule : twet_ctl_model

// file: twet_pkg.sv
// Shared constants and types for the two-wire serial memory target.
// Assumes a 250 MHz core clock and a bus clock far slower than it.
package twet_pkg;

    // ==========================================================
    // Memory geometry
    // ==========================================================
    localparam int ADDR_W = 14;
    localparam int PAGE_W = 6;
    localparam int BYTE_W = 8;
    localparam int PAGE_BYTES = 64;
    localparam int HI_ADDR_W = ADDR_W - BYTE_W;
    localparam int PAGE_NUM_W = ADDR_W - PAGE_W;

    // ==========================================================
    // Serial word layout
    // ==========================================================
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int STRAP_MSB = 3;
    localparam int STRAP_LSB = 1;
    localparam int DIR_BIT = 0;
    localparam logic [PAGE_W-1:0] PAGE_LAST = 6'h3f;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [1:0] PIN_IDLE = 2'h3;
    localparam logic [4:0] LINK_SYNC_RST = 5'h10;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 4;
    localparam int WRITE_TIME_MS = 5;
    localparam int WRITE_CYCLES = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int DETECT_LAT = 3;
    localparam int TIMER_W = 24;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        ST_DEV,
        ST_AHI,
        ST_ALO,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } twet_st_t;

    // Protocol state of the bus side, cleared by every start and stop.
    typedef struct packed {
        twet_st_t st;
        logic [3:0] cnt;
        logic [BYTE_W-1:0] sh;
        logic ack_go;
    } twet_link_t;

    // Bus-side state that survives across frames.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [PAGE_BYTES-1:0] mask;
        logic locked;
    } twet_keep_t;

    // Data line drive, updated on the falling bus clock edge.
    typedef struct packed {
        logic oe_n;
        logic o;
    } twet_drv_t;

    // Core clock side state.
    typedef struct packed {
        logic scl_q;
        logic sda_q;
        logic armed;
        logic link_rst_n;
        logic busy;
        logic [TIMER_W-1:0] timer;
        logic commit;
        logic [PAGE_W-1:0] cidx;
        logic [PAGE_NUM_W-1:0] page;
    } twet_core_t;

endpackage : twet_pkg

// file: twet_sync.sv
// Two flip-flop level synchroniser, one bit lane per input.
// Assumes each input is a slow level; multi-bit inputs must be independent.
`timescale 1ns/10ps
module twet_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ==========================================================
    // Synchroniser chain
    // ==========================================================
    logic [W-1:0] meta;

    // First stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : twet_sync

// file: twet_target.sv
// Target side of a two-wire serial memory with page write and write lock.
// Assumes scl is the bus clock port and sda is open drain with a pull-up.
//
// Operation
// - Sample data on rising bus clock edge, change output after falling edge.
// - Data line is open drain: pull low or release, never drive high.
// - Respond only when the three address bits equal the strap inputs.
// - With write lock high, acknowledge addresses, refuse first data byte, keep memory.
// - With write lock low writes are allowed; reads work at either lock level.
// - Start is data falling while clock high; needed before every access.
// - Stop is data rising while clock high; stop after read gives standby.
// - Stop after write data starts the timed internal write, then standby.
// - Words are eight bits, MSB first; receiver pulls ninth bit low.
// - After read byte release line; ack gives next byte, nack plus stop ends.
// - Without ack or stop after a read byte, stay released and silent.
// - First word: four-bit type code, three strap bits, then direction bit.
// - Matching address word is acknowledged; direction low writes, high reads.
// - Wrong type code or strap bits: no acknowledge, back to standby.
// - Write takes two address bytes then data; busy write ignores the bus.
// - Up to 64 data bytes are buffered and written in one cycle.
// - Six low address bits increment per byte and wrap within the page.
// - During internal write any address word is refused, afterwards acknowledged.
// - Internal write lasts at most five milliseconds from the stop.
`timescale 1ns/10ps
module twet_target #(
    parameter int WRITE_CYCLES = twet_pkg::WRITE_CYCLES,
    parameter logic [3:0] DEV_TYPE = 4'h5 // Arbitrary value.
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic strap_addr_bit_high,
    input wire logic strap_addr_bit_mid,
    input wire logic strap_addr_bit_low,
    input wire logic write_lock,
    output logic write_busy
);

    // ==========================================================
    // Storage
    // ==========================================================
    logic [twet_pkg::BYTE_W-1:0] mem [0:(1 << twet_pkg::ADDR_W)-1];
    logic [twet_pkg::BYTE_W-1:0] pbuf [0:twet_pkg::PAGE_BYTES-1];

    twet_pkg::twet_core_t core;
    twet_pkg::twet_core_t next_core;
    twet_pkg::twet_link_t link;
    twet_pkg::twet_link_t next_link;
    twet_pkg::twet_keep_t keep;
    twet_pkg::twet_keep_t next_keep;
    twet_pkg::twet_drv_t drv;
    twet_pkg::twet_drv_t next_drv;

    logic scl_s;
    logic sda_s;
    logic busy_s;
    logic lock_s;
    logic [2:0] strap_s;
    logic start_hit;
    logic stop_hit;
    logic buf_we;
    logic [twet_pkg::BYTE_W-1:0] byte_in;
    logic tx_bit;

    // Six low address bits step and wrap inside the page.
    function automatic logic [twet_pkg::ADDR_W-1:0] page_step(
        input logic [twet_pkg::ADDR_W-1:0] a
    );
        logic [twet_pkg::PAGE_W-1:0] lo;
        lo = a[twet_pkg::PAGE_W-1:0] + 6'h01;
        page_step = {a[twet_pkg::ADDR_W-1:twet_pkg::PAGE_W], lo};
    endfunction : page_step

    // ==========================================================
    // Core clock side: condition detection and internal write
    // ==========================================================

    // Bus pins reach core logic only through two flip-flops.
    twet_sync #(
        .W(2),
        .RST_VAL(twet_pkg::PIN_IDLE)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({scl, sda_i}),
        .q({scl_s, sda_s})
    );

    // Data only moves while clock is low, so an edge with clock high is a condition.
    assign start_hit = core.scl_q & scl_s & core.sda_q & ~sda_s;
    assign stop_hit = core.scl_q & scl_s & ~core.sda_q & sda_s;

    // Next core state: bus side reset, write timer and page commit.
    always_comb
    begin
        next_core = core;
        next_core.scl_q = scl_s;
        next_core.sda_q = sda_s;
        // Start and stop hold the bus side in reset; after a start it wakes once clock falls.
        if (start_hit)
        begin
            next_core.armed = 1'b1;
            next_core.link_rst_n = 1'b0;
        end
        else if (stop_hit)
        begin
            next_core.armed = 1'b0;
            next_core.link_rst_n = 1'b0;
        end
        else if (core.armed && !scl_s)
            next_core.link_rst_n = 1'b1;
        // Only a stop closing an accepted data phase launches a timed page write.
        if (stop_hit && !core.busy && keep.mask != '0 && !keep.locked &&
            link.st == twet_pkg::ST_WDATA)
        begin
            next_core.busy = 1'b1;
            next_core.timer = timer_cast(WRITE_CYCLES - twet_pkg::DETECT_LAT);
            next_core.commit = 1'b1;
            next_core.cidx = '0;
            next_core.page = keep.addr[twet_pkg::ADDR_W-1:twet_pkg::PAGE_W];
        end
        else if (core.busy)
        begin
            if (core.timer == '0)
                next_core.busy = 1'b0;
            else
                next_core.timer = core.timer - 24'h00_0001;
        end
        if (core.commit)
        begin
            next_core.cidx = core.cidx + 6'h01;
            if (core.cidx == twet_pkg::PAGE_LAST)
                next_core.commit = 1'b0;
        end
    end

    function automatic logic [twet_pkg::TIMER_W-1:0] timer_cast(input int v);
        timer_cast = twet_pkg::TIMER_W'(v);
    endfunction : timer_cast

    // Core state register.
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            core <= '{scl_q: 1'b1, sda_q: 1'b1, armed: 1'b0, link_rst_n: 1'b0,
                      busy: 1'b0, timer: '0, commit: 1'b0, cidx: '0, page: '0};
        else
            core <= next_core;

    // Buffered bytes move into the array one page slot per cycle.
    always_ff @(posedge clk)
        if (core.commit && keep.mask[core.cidx])
            mem[{core.page, core.cidx}] <= pbuf[core.cidx];

    assign write_busy = core.busy;

    // ==========================================================
    // Bus clock side: receive, acknowledge and transmit
    // ==========================================================

    // Busy, lock and straps enter the bus domain through two flip-flops.
    twet_sync #(
        .W(5),
        .RST_VAL(twet_pkg::LINK_SYNC_RST)
    ) u_link_sync (
        .clk(scl),
        .rst_n(core.link_rst_n),
        .d({core.busy, write_lock, strap_addr_bit_high, strap_addr_bit_mid,
            strap_addr_bit_low}),
        .q({busy_s, lock_s, strap_s})
    );

    assign byte_in = {link.sh[6:0], sda_i};

    // Next bus state, computed for the rising clock edge.
    always_comb
    begin
        next_link = link;
        next_keep = keep;
        buf_we = 1'b0;
        if (link.cnt != twet_pkg::BIT_ACK)
        begin
            // Shift one bit in per rising edge, MSB first.
            next_link.sh = byte_in;
            next_link.cnt = link.cnt + 4'h1;
            if (link.cnt == twet_pkg::BIT_LAST)
            begin
                next_link.ack_go = 1'b0;
                unique case (link.st)
                    twet_pkg::ST_DEV:
                    begin
                        // Any address word ends the old page unless a write runs.
                        if (!busy_s)
                        begin
                            next_keep.mask = '0;
                            next_keep.locked = 1'b0;
                        end
                        if (byte_in[twet_pkg::TYPE_MSB:twet_pkg::TYPE_LSB] == DEV_TYPE &&
                            byte_in[twet_pkg::STRAP_MSB:twet_pkg::STRAP_LSB] == strap_s &&
                            !busy_s)
                            next_link.ack_go = 1'b1;
                    end
                    twet_pkg::ST_AHI:
                    begin
                        next_link.ack_go = 1'b1;
                        next_keep.addr = {byte_in[twet_pkg::HI_ADDR_W-1:0],
                                          keep.addr[twet_pkg::BYTE_W-1:0]};
                    end
                    twet_pkg::ST_ALO:
                    begin
                        next_link.ack_go = 1'b1;
                        next_keep.addr[twet_pkg::BYTE_W-1:0] = byte_in;
                    end
                    twet_pkg::ST_WDATA:
                    begin
                        if (lock_s || keep.locked)
                            next_keep.locked = 1'b1;
                        else
                        begin
                            next_link.ack_go = 1'b1;
                            buf_we = 1'b1;
                            next_keep.mask[keep.addr[twet_pkg::PAGE_W-1:0]] = 1'b1;
                            next_keep.addr = page_step(keep.addr);
                        end
                    end
                    twet_pkg::ST_RDATA, twet_pkg::ST_IGNORE:
                        next_link.ack_go = 1'b0;
                endcase
            end
        end
        else
        begin
            // Ninth clock: move on once the acknowledge bit has passed.
            next_link.cnt = '0;
            next_link.ack_go = 1'b0;
            unique case (link.st)
                twet_pkg::ST_DEV:
                    if (!link.ack_go)
                        next_link.st = twet_pkg::ST_IGNORE;
                    else if (link.sh[twet_pkg::DIR_BIT])
                        next_link.st = twet_pkg::ST_RDATA;
                    else
                        next_link.st = twet_pkg::ST_AHI;
                twet_pkg::ST_AHI:
                    next_link.st = twet_pkg::ST_ALO;
                twet_pkg::ST_ALO:
                    next_link.st = twet_pkg::ST_WDATA;
                twet_pkg::ST_WDATA:
                    if (keep.locked)
                        next_link.st = twet_pkg::ST_IGNORE;
                twet_pkg::ST_RDATA:
                    if (!sda_i)
                        next_keep.addr = keep.addr + 14'h0001;
                    else
                        next_link.st = twet_pkg::ST_IGNORE;
                twet_pkg::ST_IGNORE:
                    next_link.st = twet_pkg::ST_IGNORE;
            endcase
        end
    end

    // Protocol state restarts at the address word after every start.
    always_ff @(posedge scl or negedge core.link_rst_n)
        if (!core.link_rst_n)
            link <= '{st: twet_pkg::ST_DEV, cnt: '0, sh: '0, ack_go: 1'b0};
        else
            link <= next_link;

    // Address counter and page record outlive the frame.
    always_ff @(posedge scl or negedge rst_n)
        if (!rst_n)
            keep <= '{addr: '0, mask: '0, locked: 1'b0};
        else
            keep <= next_keep;

    // Page buffer, indexed by the low address bits.
    always_ff @(posedge scl)
        if (buf_we)
            pbuf[keep.addr[twet_pkg::PAGE_W-1:0]] <= byte_in;

    // Read bits leave MSB first from the current address.
    assign tx_bit = mem[keep.addr][3'(~link.cnt[2:0])];

    // Drive low only for an acknowledge or a zero read bit.
    always_comb
    begin
        next_drv.o = 1'b0;
        next_drv.oe_n = !((link.cnt == twet_pkg::BIT_ACK && link.ack_go) ||
                          (link.st == twet_pkg::ST_RDATA &&
                           link.cnt != twet_pkg::BIT_ACK && !tx_bit));
    end

    // Output changes only after the falling clock edge.
    always_ff @(negedge scl or negedge core.link_rst_n)
        if (!core.link_rst_n)
            drv <= '{oe_n: 1'b1, o: 1'b0};
        else
            drv <= next_drv;

    assign sda_o = drv.o;
    assign sda_oe_n = drv.oe_n;

    // ==========================================================
    // Checks
    // ==========================================================
    pull_only_a: assert property (@(posedge clk) disable iff (!rst_n) sda_o == 1'b0)
        else $error("data line driven high");

    start_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        start_hit |=> !core.link_rst_n)
        else $error("start did not restart bus side");

    stop_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (stop_hit && !core.busy && keep.mask != '0 && !keep.locked &&
         link.st == twet_pkg::ST_WDATA)
        |=> core.busy && core.commit)
        else $error("stop after data did not start write");

    write_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        core.busy |-> core.timer <= timer_cast(WRITE_CYCLES))
        else $error("write timer beyond limit");

    commit_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        core.commit |-> core.busy)
        else $error("commit outside internal write");

    mismatch_nack_a: assert property (@(posedge scl) disable iff (!core.link_rst_n)
        (link.st == twet_pkg::ST_DEV && link.cnt == twet_pkg::BIT_LAST &&
         byte_in[twet_pkg::STRAP_MSB:twet_pkg::STRAP_LSB] != strap_s)
        |=> !link.ack_go ##1 link.st == twet_pkg::ST_IGNORE)
        else $error("foreign address acknowledged");

    busy_nack_a: assert property (@(posedge scl) disable iff (!core.link_rst_n)
        (link.st == twet_pkg::ST_DEV && link.cnt == twet_pkg::BIT_LAST && busy_s)
        |=> !link.ack_go)
        else $error("address acknowledged during write");

    lock_nack_a: assert property (@(posedge scl) disable iff (!core.link_rst_n)
        (link.st == twet_pkg::ST_WDATA && link.cnt == twet_pkg::BIT_LAST && lock_s)
        |=> !link.ack_go && keep.locked && !$changed(keep.mask))
        else $error("locked data byte accepted");

    page_wrap_a: assert property (@(posedge scl) disable iff (!core.link_rst_n)
        (link.st == twet_pkg::ST_WDATA && link.cnt == twet_pkg::BIT_LAST && buf_we)
        |=> keep.addr == page_step($past(keep.addr)))
        else $error("page address step wrong");

    read_next_a: assert property (@(posedge scl) disable iff (!core.link_rst_n)
        (link.st == twet_pkg::ST_RDATA && link.cnt == twet_pkg::BIT_ACK && !sda_i)
        |=> keep.addr == $past(keep.addr) + 14'h0001)
        else $error("read address did not advance");

    silent_a: assert property (@(negedge scl) disable iff (!core.link_rst_n)
        link.st == twet_pkg::ST_IGNORE |=> drv.oe_n)
        else $error("line driven while ignoring");

endmodule : twet_target

// file: two_wire_eeprom_target_bench.sv
// Self-checking bench for the two-wire serial memory target.
// Assumes the controller model twet_ctl_model and the design package.
`timescale 1ns/10ps
module two_wire_eeprom_target_bench;
    localparam logic [3:0] DEV_TYPE = 4'h6; // Arbitrary value.
    localparam logic [2:0] STRAP = 3'h5;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic write_lock = 1'b0;
    logic scl, sda_rel, sda_o, sda_oe_n, write_busy;
    wire logic sda;
    int failures = 0;
    int num_checks = 0;

    // Pull-up data line, low while either party pulls it.
    assign sda = sda_rel & (sda_oe_n | sda_o);

    // Core clock.
    always #2 clk = ~clk;

    twet_target #(.WRITE_CYCLES(200), .DEV_TYPE(DEV_TYPE)) i_dut (
        .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .strap_addr_bit_high(STRAP[2]),
        .strap_addr_bit_mid(STRAP[1]), .strap_addr_bit_low(STRAP[0]),
        .write_lock(write_lock), .write_busy(write_busy));

    twet_ctl_model i_ctl (.scl(scl), .sda_rel(sda_rel), .sda(sda));

    // ==========================================================
    // Helpers
    // ==========================================================
    // Compares and counts.
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Prints the verdict and stops.
    task automatic end_sim;
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // Opens a frame with an address word.
    task automatic addr_word(input logic [3:0] typ, input logic [2:0] st, input logic rd,
        output logic a);
        i_ctl.start();
        i_ctl.wbyte({typ, st, rd}, a);
    endtask : addr_word

    // Write-direction frame that loads the memory address.
    task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
        logic a;
        addr_word(DEV_TYPE, STRAP, 1'b0, a);
        chk("addr ack", 8'(a), 8'h00);
        i_ctl.wbyte(hi, a);
        chk("hi ack", 8'(a), 8'h00);
        i_ctl.wbyte(lo, a);
        chk("lo ack", 8'(a), 8'h00);
    endtask : set_addr

    // Random read of a run, last byte refused, then one more byte must stay released.
    task automatic read_run(input logic [7:0] hi, input logic [7:0] lo,
        input logic [7:0] exp [$]);
        logic a;
        logic [7:0] d;
        set_addr(hi, lo);
        addr_word(DEV_TYPE, STRAP, 1'b1, a);
        chk("rd ack", 8'(a), 8'h00);
        foreach (exp[i])
        begin
            i_ctl.rbyte(i == exp.size() - 1, d);
            chk("rd data", d, exp[i]);
        end
        i_ctl.rbyte(1'b1, d);
        chk("rd silent", d, 8'hff);
        i_ctl.stop();
    endtask : read_run

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Wrong strap bits one at a time and a wrong type code are refused.
    task automatic t_mismatch;
        logic a;
        for (int i = 0; i < 4; i++)
        begin
            addr_word(i == 3 ? DEV_TYPE ^ 4'h8 : DEV_TYPE,
                i == 3 ? STRAP : STRAP ^ 3'(1 << i), 1'b0, a);
            chk("mismatch nack", 8'(a), 8'h01);
            i_ctl.stop();
        end
    endtask : t_mismatch

    // Page write across the page end, polling, and read back.
    task automatic t_page_write;
        logic a;
        int n;
        set_addr(8'hc1, 8'h7e);
        for (int i = 0; i < 3; i++)
        begin
            i_ctl.wbyte(8'ha1 + 8'(i * 17), a);
            chk("data ack", 8'(a), 8'h00);
        end
        i_ctl.stop();
        repeat (8) @(negedge clk);
        chk("busy", 8'(write_busy), 8'h01);
        addr_word(DEV_TYPE, STRAP, 1'b0, a);
        chk("poll nack", 8'(a), 8'h01);
        n = 0;
        while (a !== 1'b0 && n < 8)
        begin
            i_ctl.stop();
            addr_word(DEV_TYPE, STRAP, 1'b0, a);
            n++;
        end
        chk("poll ack", 8'(a), 8'h00);
        chk("idle", 8'(write_busy), 8'h00);
        i_ctl.stop();
        read_run(8'h01, 8'h7e, '{8'ha1, 8'hb2});
        read_run(8'h01, 8'h40, '{8'hc3});
    endtask : t_page_write

    // Locked write is refused at its data byte and leaves memory alone.
    task automatic t_lock;
        logic a;
        @(negedge clk);
        write_lock = 1'b1;
        set_addr(8'h01, 8'h40);
        i_ctl.wbyte(8'h5a, a);
        chk("lock nack", 8'(a), 8'h01);
        i_ctl.stop();
        repeat (40) @(negedge clk);
        chk("lock busy", 8'(write_busy), 8'h00);
        chk("drive level", 8'(sda_o), 8'h00);
        read_run(8'h01, 8'h40, '{8'hc3});
        @(negedge clk);
        write_lock = 1'b0;
    endtask : t_lock

    // Main sequence.
    initial
    begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_mismatch();
        t_page_write();
        t_lock();
        end_sim();
    end

    // Watchdog, several times the expected run of about 22 us.
    initial
    begin
        #200000;
        failures++;
        end_sim();
    end
endmodule : two_wire_eeprom_target_bench
